//--- tb/lin_slave_config_handler_tb.sv
`timescale 1ns/10ps
module lin_slave_config_handler_tb;
	import lscfg_pkg::*;
	localparam logic [15:0] SUP = 16'h00A5; // arbitrary value
	localparam logic [15:0] FUN = 16'h005A; // arbitrary value
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic io_frame_seen = 1'b0;
	logic pin_cfg_written = 1'b0;
	logic pu_any = 1'b0;
	logic [2:0] cfg_pin_in = 3'h5;
	logic req_valid, resp_poll, resp_valid, cfg_pin_3_out, cfg_pin_3_oe, cfg_pullup_en;
	logic chain_drv_en, chain_pass_switch, pin_cfg_active, pin_cfg_pending;
	lscfg_frame_t req_frame, resp_frame;
	lscfg_fid_t io_request_frame, io_response_frame;
	logic [7:0] node_addr;
	int err_count = 0;
	int tests_run = 0;
	int cycles = 0;
	int pu_at = -1;

	always #4 clk_sys = ~clk_sys;

	lscfg_handler #(.SUPPLIER_CODE(SUP), .FUNCTION_CODE(FUN)) dut (.clk_sys(clk_sys),
		.rstn(rstn), .cfg_pin_in(cfg_pin_in), .cfg_pin_3_out(cfg_pin_3_out),
		.cfg_pin_3_oe(cfg_pin_3_oe), .cfg_pullup_en(cfg_pullup_en), .chain_drv_en(chain_drv_en),
		.chain_pass_switch(chain_pass_switch), .req_valid(req_valid), .req_frame(req_frame),
		.resp_poll(resp_poll), .resp_valid(resp_valid), .resp_frame(resp_frame),
		.io_frame_seen(io_frame_seen), .pin_cfg_written(pin_cfg_written),
		.io_request_frame(io_request_frame), .io_response_frame(io_response_frame),
		.pin_cfg_active(pin_cfg_active), .pin_cfg_pending(pin_cfg_pending),
		.node_addr(node_addr));
	lscfg_master_model master (.clk_sys(clk_sys), .req_valid(req_valid),
		.req_frame(req_frame), .resp_poll(resp_poll));

	// pull-ups are only on for a cycle or so, so remember any sighting
	always @(negedge clk_sys) if (cfg_pullup_en === 1'b1) pu_at = cycles;

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	task automatic chk(input string n, input logic [71:0] s, input logic [71:0] e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	function automatic lscfg_frame_t nreq(input logic [7:0] d0, input logic [7:0] nad);
		return {nad, FUN[15:8], FUN[7:0], SUP[15:8], SUP[7:0], LSCFG_SID_ASSIGN_NAD,
			LSCFG_PCI_REQ, d0};
	endfunction : nreq

	function automatic lscfg_frame_t fidr(input logic [7:0] nad, input logic [15:0] sel,
		input logic [7:0] pid);
		return {pid, sel[15:8], sel[7:0], SUP[15:8], SUP[7:0], LSCFG_SID_ASSIGN_ID,
			LSCFG_PCI_REQ, nad};
	endfunction : fidr

	function automatic logic [63:0] rsp(input logic [7:0] rs, input logic [7:0] d0);
		return {{5{LSCFG_FILL}}, rs, LSCFG_PCI_RESP, d0};
	endfunction : rsp

	task automatic go(input lscfg_frame_t f);
		int t0;
		t0 = cycles;
		master.send(f);
		#1;
		pu_any = (pu_at >= t0);
	endtask : go

	task automatic poll_clear();
		master.poll();
		#1;
		chk("resp_valid after poll", resp_valid, 1'b0);
	endtask : poll_clear

	task automatic t_reset();
		chk("node_addr", node_addr, LSCFG_NAD_BASE + 8'h05);
		chk("ids", {io_request_frame, io_response_frame, pin_cfg_active}, '0);
		chk("idle pins", {chain_pass_switch, chain_drv_en, resp_valid, cfg_pullup_en}, '0);
	endtask : t_reset

	task automatic t_plug();
		lscfg_frame_t f;
		f = nreq(8'h0D, 8'h50);
		f.d3 = ~SUP[7:0];
		go(f);
		chk("bad supplier", {node_addr, resp_valid, pu_any}, {8'h65, 2'b00});
		go(nreq(8'h0C, 8'h50));
		chk("plug pins differ", {node_addr, resp_valid}, {8'h65, 1'b0});
		go(nreq(8'h1D, 8'h50));
		chk("plug high bits", {node_addr, resp_valid}, {8'h65, 1'b0});
		go(nreq(8'h0D, 8'h12));
		chk("plug hit", {node_addr, pu_any}, {8'h12, 1'b1});
		chk("plug resp", {resp_valid, resp_frame}, {1'b1, rsp(LSCFG_RSID_ASSIGN_NAD, 8'h0D)});
		poll_clear();
	endtask : t_plug

	task automatic t_fid();
		@(posedge clk_sys) pin_cfg_written <= 1'b1;
		@(posedge clk_sys) pin_cfg_written <= 1'b0;
		#1;
		chk("cfg pending", {pin_cfg_pending, pin_cfg_active}, 2'b10);
		go(fidr(8'h7F, LSCFG_SEL_BOTH, 8'h55));
		chk("other node", {io_request_frame, io_response_frame, resp_valid, pu_any}, '0);
		@(posedge clk_sys) io_frame_seen <= 1'b1;
		@(posedge clk_sys) io_frame_seen <= 1'b0;
		#1;
		chk("cfg active", pin_cfg_active, 1'b1);
		go(fidr(8'h12, LSCFG_SEL_BOTH, 8'h20));
		chk("sel both", {io_request_frame, io_response_frame}, {8'h20, 1'b1, 8'h21, 1'b1});
		chk("fid resp", {resp_valid, resp_frame}, {1'b1, rsp(LSCFG_RSID_ASSIGN_ID, 8'h12)});
		go(fidr(8'h12, LSCFG_SEL_RESP, 8'h30));
		chk("sel resp", {io_request_frame, io_response_frame}, {8'h20, 1'b1, 8'h30, 1'b1});
		go(fidr(8'h12, LSCFG_SEL_REQ, 8'h40));
		chk("sel req", {io_request_frame, io_response_frame}, {8'h40, 1'b1, 8'h30, 1'b1});
		go(fidr(8'h12, 16'h0003, 8'h50));
		chk("sel bad", {io_request_frame, io_response_frame, resp_valid},
			{8'h40, 1'b1, 8'h30, 1'b1, 1'b0});
		poll_clear();
	endtask : t_fid

	task automatic t_chain();
		go(nreq(LSCFG_DC_ON, 8'h00));
		chk("chain on", {chain_drv_en, resp_valid}, 2'b10);
		go(nreq(LSCFG_DC_ASSIGN, 8'h33));
		chk("pin1 high", {node_addr, chain_pass_switch}, {8'h12, 1'b0});
		@(posedge clk_sys) cfg_pin_in <= 3'h4;
		go(nreq(LSCFG_DC_ASSIGN, 8'h33));
		chk("chain hit", {node_addr, chain_pass_switch, cfg_pin_3_oe, cfg_pin_3_out}, {8'h33, 3'b110});
		chk("reassign", {io_request_frame, io_response_frame, pin_cfg_active}, '0);
		chk("chain resp", {resp_valid, resp_frame}, {1'b1, rsp(LSCFG_RSID_ASSIGN_NAD, 8'h21)});
		poll_clear();
		go(nreq(LSCFG_DC_ASSIGN, 8'h44));
		chk("switch closed", {node_addr, chain_pass_switch}, {8'h33, 1'b1});
		go(nreq(LSCFG_DC_OFF, 8'h00));
		chk("chain off", {chain_pass_switch, chain_drv_en, resp_valid}, 3'b000);
	endtask : t_chain

	initial begin
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		t_reset();
		t_plug();
		t_fid();
		t_chain();
		stop_test();
	end
endmodule : lin_slave_config_handler_tb

//--- tb/lscfg_master_model.sv
`timescale 1ns/10ps
// master node side: whole requests in one beat, answers fetched by a poll pulse
module lscfg_master_model
	import lscfg_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// request and poll
	output logic req_valid,
	output lscfg_frame_t req_frame,
	output logic resp_poll
);
	initial begin
		req_valid = 1'b0;
		req_frame = '0;
		resp_poll = 1'b0;
	end
	// all eight bytes travel together; idle cycles after keep the request spacing
	task automatic send(input lscfg_frame_t f);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_frame <= f;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		req_frame <= ~f; // released bytes never repeat the last value
		repeat (3) @(posedge clk_sys);
	endtask : send
	task automatic poll();
		@(posedge clk_sys);
		resp_poll <= 1'b1;
		@(posedge clk_sys);
		resp_poll <= 1'b0;
	endtask : poll
endmodule : lscfg_master_model

//--- verilog/lscfg_fid_slot.sv
`timescale 1ns/10ps
// one message frame identifier slot; cleared whenever the node address changes
module lscfg_fid_slot
	import lscfg_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// control
	input wire logic clr,
	input wire logic load,
	input wire logic [7:0] pid,
	// state
	output lscfg_fid_t slot
);
	lscfg_fid_t slot_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			slot_q <= '{pid: LSCFG_ID_RESET, en: 1'b0};
		end else if (load) begin
			slot_q <= '{pid: pid, en: 1'b1};
		end else if (clr) begin
			slot_q <= '{pid: LSCFG_ID_RESET, en: 1'b0};
		end
	end

	assign slot = slot_q;
endmodule : lscfg_fid_slot

//--- verilog/lscfg_handler.sv
`timescale 1ns/10ps
module lscfg_handler
	import lscfg_pkg::*;
#(
	parameter logic [15:0] SUPPLIER_CODE = 16'h00A5, // arbitrary value
	parameter logic [15:0] FUNCTION_CODE = 16'h005A  // arbitrary value
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// configuration pins
	input wire logic [2:0] cfg_pin_in,
	output logic cfg_pin_3_out,
	output logic cfg_pin_3_oe,
	output logic cfg_pullup_en,
	output logic chain_drv_en,
	output logic chain_pass_switch,
	// master request frame from protocol engine
	input wire logic req_valid,
	input lscfg_frame_t req_frame,
	// slave response poll
	input wire logic resp_poll,
	output logic resp_valid,
	output lscfg_frame_t resp_frame,
	// io message frames
	input wire logic io_frame_seen,
	input wire logic pin_cfg_written,
	output lscfg_fid_t io_request_frame,
	output lscfg_fid_t io_response_frame,
	output logic pin_cfg_active,
	output logic pin_cfg_pending,
	output logic [7:0] node_addr
);
	typedef enum logic [1:0] {
		LSCFG_ST_SAMPLE = 2'b00,
		LSCFG_ST_IDLE = 2'b01,
		LSCFG_ST_ASSIGN = 2'b10
	} lscfg_state_t;

	lscfg_state_t state_q;
	logic [7:0] nad_q;
	logic sw_q;
	logic drv_q;
	logic resp_valid_q;
	lscfg_frame_t resp_q;
	logic cfg_act_q;
	logic cfg_pend_q;
	lscfg_frame_t rq_q;

	// decode of a latched request
	logic codes_ok;
	logic is_nad_req;
	logic is_id_req;
	logic plug_hit;
	logic dc_assign_hit;
	logic nad_load;
	logic id_load;
	logic [15:0] sel;
	logic sel_ok;
	logic req_ld;
	logic rsp_ld;

	assign codes_ok = ({rq_q.d4, rq_q.d3} == SUPPLIER_CODE);
	assign is_nad_req = (rq_q.d2 == LSCFG_SID_ASSIGN_NAD) && codes_ok
		&& ({rq_q.d6, rq_q.d5} == FUNCTION_CODE);
	assign is_id_req = (rq_q.d0 == nad_q) && (rq_q.d2 == LSCFG_SID_ASSIGN_ID) && codes_ok;
	assign plug_hit = (rq_q.d0[7:4] == LSCFG_PLUG_HI) && rq_q.d0[LSCFG_PLUG_BIT]
		&& (rq_q.d0[2:0] == cfg_pin_in);
	assign dc_assign_hit = (rq_q.d0 == LSCFG_DC_ASSIGN) && !cfg_pin_in[0] && !sw_q;
	assign nad_load = (state_q == LSCFG_ST_ASSIGN) && is_nad_req && (plug_hit || dc_assign_hit);
	assign sel = {rq_q.d6, rq_q.d5};
	assign sel_ok = (sel == LSCFG_SEL_BOTH) || (sel == LSCFG_SEL_RESP) || (sel == LSCFG_SEL_REQ);
	assign id_load = (state_q == LSCFG_ST_ASSIGN) && is_id_req && sel_ok;
	assign req_ld = id_load && (sel != LSCFG_SEL_RESP);
	assign rsp_ld = id_load && (sel != LSCFG_SEL_REQ);

	// request is latched, then evaluated in one assign cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= LSCFG_ST_SAMPLE;
		end else begin
			unique case (state_q)
				LSCFG_ST_SAMPLE: state_q <= LSCFG_ST_IDLE;
				LSCFG_ST_IDLE: begin
					if (req_valid) begin
						state_q <= LSCFG_ST_ASSIGN;
					end
				end
				LSCFG_ST_ASSIGN: state_q <= LSCFG_ST_IDLE;
				default: state_q <= LSCFG_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rq_q <= '0;
		end else if (state_q == LSCFG_ST_IDLE && req_valid) begin
			rq_q <= req_frame;
		end
	end

	// pins are caught in the first clocked cycle after reset release
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			nad_q <= LSCFG_NAD_BASE;
		end else if (state_q == LSCFG_ST_SAMPLE) begin
			nad_q <= LSCFG_NAD_BASE + {5'h00, cfg_pin_in};
		end else if (nad_load) begin
			nad_q <= rq_q.d7;
		end
	end

	// switch and chain drivers change only on fully valid requests
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sw_q <= 1'b0;
			drv_q <= 1'b0;
		end else if (state_q == LSCFG_ST_ASSIGN && is_nad_req) begin
			if (dc_assign_hit) begin
				sw_q <= 1'b1;
			end else if (rq_q.d0 == LSCFG_DC_OFF) begin
				sw_q <= 1'b0;
				drv_q <= 1'b0;
			end else if (rq_q.d0 == LSCFG_DC_ON) begin
				drv_q <= 1'b1;
			end
		end
	end

	// response is held until polled or retired by a new own request; other-node traffic leaves it pending
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			resp_valid_q <= 1'b0;
			resp_q <= '0;
		end else if (nad_load) begin
			resp_valid_q <= 1'b1;
			resp_q <= '{d0: rq_q.d0, d1: LSCFG_PCI_RESP, d2: LSCFG_RSID_ASSIGN_NAD,
				default: LSCFG_FILL};
		end else if (id_load) begin
			resp_valid_q <= 1'b1;
			resp_q <= '{d0: nad_q, d1: LSCFG_PCI_RESP, d2: LSCFG_RSID_ASSIGN_ID,
				default: LSCFG_FILL};
		end else if (resp_poll) begin
			resp_valid_q <= 1'b0;
		end else if (state_q == LSCFG_ST_ASSIGN && (is_id_req || rq_q.d0 == nad_q)) begin
			resp_valid_q <= 1'b0; // a new own request retires an old answer
		end
	end

	// pin configuration: staged blocks go live at first io frame
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_act_q <= 1'b0;
			cfg_pend_q <= 1'b0;
		end else if (nad_load) begin
			cfg_act_q <= 1'b0;
			cfg_pend_q <= 1'b0;
		end else if (pin_cfg_written) begin
			cfg_pend_q <= 1'b1;
		end else if (io_frame_seen && cfg_pend_q) begin
			cfg_act_q <= 1'b1;
			cfg_pend_q <= 1'b0;
		end
	end

	lscfg_fid_slot u_req_slot (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.clr(nad_load),
		.load(req_ld),
		.pid(rq_q.d7),
		.slot(io_request_frame)
	);

	lscfg_fid_slot u_rsp_slot (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.clr(nad_load),
		.load(rsp_ld),
		.pid((sel == LSCFG_SEL_BOTH) ? rq_q.d7 + LSCFG_PID_INC : rq_q.d7),
		.slot(io_response_frame)
	);

	// pull-ups only during the evaluation; keeps standby current away
	assign cfg_pullup_en = (state_q == LSCFG_ST_ASSIGN) && is_nad_req;
	assign chain_pass_switch = sw_q;
	assign chain_drv_en = drv_q;
	// closed switch forwards the chain low level out on pin 3
	assign cfg_pin_3_oe = sw_q;
	assign cfg_pin_3_out = 1'b0;
	assign resp_valid = resp_valid_q;
	assign resp_frame = resp_q;
	assign pin_cfg_active = cfg_act_q;
	assign pin_cfg_pending = cfg_pend_q;
	assign node_addr = nad_q;

	property p_por_nad;
		@(posedge clk_sys) disable iff (!rstn)
		state_q == LSCFG_ST_SAMPLE |=> nad_q == LSCFG_NAD_BASE + {5'h00, $past(cfg_pin_in)};
	endproperty
	a_por_nad: assert property (p_por_nad) else $error("bad power-on address");

	property p_nad_resp;
		@(posedge clk_sys) disable iff (!rstn)
		nad_load |=> resp_valid && resp_frame.d2 == LSCFG_RSID_ASSIGN_NAD
			&& resp_frame.d1 == LSCFG_PCI_RESP && resp_frame.d7 == LSCFG_FILL;
	endproperty
	a_nad_resp: assert property (p_nad_resp) else $error("bad assign address answer");

	property p_id_resp;
		@(posedge clk_sys) disable iff (!rstn)
		id_load |=> resp_valid && resp_frame.d0 == $past(nad_q)
			&& resp_frame.d2 == LSCFG_RSID_ASSIGN_ID;
	endproperty
	a_id_resp: assert property (p_id_resp) else $error("bad assign id answer");

	property p_no_resp_dc;
		@(posedge clk_sys) disable iff (!rstn)
		// an older unpolled answer may still stand; only a new one is forbidden
		state_q == LSCFG_ST_ASSIGN && is_nad_req
			&& (rq_q.d0 == LSCFG_DC_ON || rq_q.d0 == LSCFG_DC_OFF)
			|=> !$rose(resp_valid) && $stable(resp_frame);
	endproperty
	a_no_resp_dc: assert property (p_no_resp_dc) else $error("answer to chain on/off");

	property p_sw_open;
		@(posedge clk_sys) disable iff (!rstn)
		$fell(sw_q) |-> $past(rq_q.d0) == LSCFG_DC_OFF && $past(is_nad_req);
	endproperty
	a_sw_open: assert property (p_sw_open) else $error("switch opened wrongly");

	property p_sw_close;
		@(posedge clk_sys) disable iff (!rstn)
		$rose(sw_q) |-> $past(cfg_pin_in[0]) == 1'b0 && $past(nad_load);
	endproperty
	a_sw_close: assert property (p_sw_close) else $error("switch closed wrongly");

	property p_reassign_clr;
		@(posedge clk_sys) disable iff (!rstn)
		nad_load |=> !io_request_frame.en && !io_response_frame.en && !pin_cfg_active;
	endproperty
	a_reassign_clr: assert property (p_reassign_clr) else $error("ids kept on reassign");

	property p_both_ids;
		@(posedge clk_sys) disable iff (!rstn)
		id_load && sel == LSCFG_SEL_BOTH |=>
			io_response_frame.pid == io_request_frame.pid + LSCFG_PID_INC;
	endproperty
	a_both_ids: assert property (p_both_ids) else $error("bad id pair");

	property p_pullup;
		@(posedge clk_sys) disable iff (!rstn)
		cfg_pullup_en |-> state_q == LSCFG_ST_ASSIGN && $past(req_valid)
			&& $past(req_frame.d2) == LSCFG_SID_ASSIGN_NAD;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up outside assign");

	property p_nad_change;
		@(posedge clk_sys) disable iff (!rstn)
		$changed(nad_q) && $past(state_q) != LSCFG_ST_SAMPLE |-> $past(nad_load);
	endproperty
	a_nad_change: assert property (p_nad_change) else $error("address changed");

	property p_plug_nad;
		@(posedge clk_sys) disable iff (!rstn)
		state_q == LSCFG_ST_ASSIGN && is_nad_req
			&& rq_q.d0 == {LSCFG_PLUG_HI, 1'b1, cfg_pin_in} |=> node_addr == $past(rq_q.d7);
	endproperty
	a_plug_nad: assert property (p_plug_nad) else $error("plug address not taken");

	property p_keep_on_miss;
		@(posedge clk_sys) disable iff (!rstn)
		state_q == LSCFG_ST_ASSIGN && !is_nad_req && !id_load |=> $stable(node_addr)
			&& $stable(chain_pass_switch) && $stable(chain_drv_en)
			&& $stable(io_request_frame) && $stable(io_response_frame);
	endproperty
	a_keep_on_miss: assert property (p_keep_on_miss) else $error("state moved on miss");

	property p_drv_on;
		@(posedge clk_sys) disable iff (!rstn)
		state_q == LSCFG_ST_ASSIGN && is_nad_req && rq_q.d0 == LSCFG_DC_ON |=> chain_drv_en;
	endproperty
	a_drv_on: assert property (p_drv_on) else $error("chain drivers not on");

	property p_resp_hold;
		@(posedge clk_sys) disable iff (!rstn)
		resp_valid && !resp_poll && state_q != LSCFG_ST_ASSIGN
			|=> resp_valid && $stable(resp_frame);
	endproperty
	a_resp_hold: assert property (p_resp_hold) else $error("answer dropped unpolled");

	property p_poll_clear;
		@(posedge clk_sys) disable iff (!rstn)
		resp_poll && !nad_load && !id_load |=> !resp_valid;
	endproperty
	a_poll_clear: assert property (p_poll_clear) else $error("answer kept after poll");

	property p_cfg_live;
		@(posedge clk_sys) disable iff (!rstn)
		$rose(pin_cfg_active) |-> $past(io_frame_seen) && $past(pin_cfg_pending);
	endproperty
	a_cfg_live: assert property (p_cfg_live) else $error("config live too early");

	property p_drv_gate;
		@(posedge clk_sys) disable iff (!rstn)
		$changed(chain_drv_en) |-> $past(state_q) == LSCFG_ST_ASSIGN && $past(is_nad_req);
	endproperty
	a_drv_gate: assert property (p_drv_gate) else $error("drivers moved wrongly");

	// other-node traffic must not touch a pending answer
	property p_other_node;
		@(posedge clk_sys) disable iff (!rstn)
		state_q == LSCFG_ST_ASSIGN && !is_nad_req && rq_q.d0 != nad_q && !resp_poll
			|=> $stable(resp_valid) && $stable(resp_frame);
	endproperty
	a_other_node: assert property (p_other_node) else $error("answer hit by other node");

	c_plug: cover property (@(posedge clk_sys) disable iff (!rstn) nad_load && plug_hit);
	c_chain: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(sw_q));
	c_id: cover property (@(posedge clk_sys) disable iff (!rstn) id_load);
	c_cfg: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(cfg_act_q));
	c_dc_off: cover property (@(posedge clk_sys) disable iff (!rstn) $fell(sw_q));
endmodule : lscfg_handler

//--- verilog/lscfg_pkg.sv
package lscfg_pkg;
	localparam int LSCFG_NBYTES = 8;
	localparam logic [7:0] LSCFG_NAD_BASE = 8'h60;
	localparam logic [7:0] LSCFG_PCI_REQ = 8'h06;
	localparam logic [7:0] LSCFG_PCI_RESP = 8'h01;
	localparam logic [7:0] LSCFG_SID_ASSIGN_NAD = 8'hB0;
	localparam logic [7:0] LSCFG_SID_ASSIGN_ID = 8'hB1;
	localparam logic [7:0] LSCFG_RSID_ASSIGN_NAD = 8'hF0;
	localparam logic [7:0] LSCFG_RSID_ASSIGN_ID = 8'hF1;
	localparam logic [7:0] LSCFG_FILL = 8'hFF;
	localparam logic [7:0] LSCFG_DC_ON = 8'h20;
	localparam logic [7:0] LSCFG_DC_ASSIGN = 8'h21;
	localparam logic [7:0] LSCFG_DC_OFF = 8'h23;
	localparam logic [3:0] LSCFG_PLUG_HI = 4'h0;
	localparam logic [15:0] LSCFG_SEL_BOTH = 16'h0000;
	localparam logic [15:0] LSCFG_SEL_RESP = 16'h0001;
	localparam logic [15:0] LSCFG_SEL_REQ = 16'h0002;
	localparam logic [7:0] LSCFG_PID_INC = 8'h01;
	localparam logic [7:0] LSCFG_ID_RESET = 8'h00;
	localparam int LSCFG_B_NAD = 0;
	localparam int LSCFG_B_PCI = 1;
	localparam int LSCFG_B_SID = 2;
	localparam int LSCFG_B_SUP = 3;
	localparam int LSCFG_B_FUN = 5;
	localparam int LSCFG_B_ARG = 7;
	localparam int LSCFG_PLUG_BIT = 3;

	typedef struct packed {
		logic [7:0] d7;
		logic [7:0] d6;
		logic [7:0] d5;
		logic [7:0] d4;
		logic [7:0] d3;
		logic [7:0] d2;
		logic [7:0] d1;
		logic [7:0] d0;
	} lscfg_frame_t;

	typedef struct packed {
		logic [7:0] pid;
		logic en;
	} lscfg_fid_t;
endpackage : lscfg_pkg
